// ===== logic/fcc_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FCC_CONSTS_SVH
`define FCC_CONSTS_SVH
`define FCC_ADDR_CFG6       8'h10
`define FCC_ADDR_CFG3       8'h78
`define FCC_ADDR_TMR_STAT   8'h79
`define FCC_ADDR_TMR_LIMIT  8'h7a
`define FCC_ADDR_TACH_PULSE 8'h7b
`define FCC_ADDR_CFG5       8'h7c
`define FCC_ADDR_CFG4       8'h7d
`define FCC_ADDR_TEST1      8'h7e
`define FCC_ADDR_TEST2      8'h7f
`define FCC_RST_CFG6        8'h00
`define FCC_RST_CFG3        8'h00
`define FCC_RST_TMR_LIMIT   8'h00
`define FCC_RST_TACH_PULSE  8'h55
`define FCC_RST_CFG5        8'h01
`define FCC_RST_CFG4        8'h00
`define FCC_RST_TEST        8'h00
`define FCC_BIT_R1_SLOW     0
`define FCC_BIT_LOC_SLOW    1
`define FCC_BIT_R2_SLOW     2
`define FCC_BIT_OT_MANUAL   3
`define FCC_BIT_FOLLOWER    4
`define FCC_BIT_LEADER      5
`define FCC_BIT_VLOW_SLEEP  6
`define FCC_BIT_EXTRA_SLOW  7
`define FCC_BIT_TWOS        0
`define FCC_SLOW_SHIFT      2
`define FCC_EXTRA_NUM       16'd1392
`define FCC_EXTRA_DEN       16'd1000
`define FCC_SPINUP_NS       2000000
`define FCC_CLK_NS          25
`define FCC_SPINUP_CYC      (`FCC_SPINUP_NS / `FCC_CLK_NS)
`endif

// ===== logic/fcc_pkg.sv
// Types shared by the fan configuration register slice
package fcc_pkg;
   typedef struct packed {
      logic       wr_en;   // One-cycle write strobe
      logic       rd_en;   // One-cycle read strobe
      logic [7:0] addr;    // Register pointer
      logic [7:0] wdata;   // Write data
   } fcc_req_t;

   typedef struct packed {
      logic [2:0] slow_x4;     // Per-channel x4 smoothing stretch
      logic       extra;       // Extra 39.2 percent stretch
      logic       ot_manual;   // Overtemperature kept in manual mode
      logic       follower;    // Fan sync follower
      logic       leader;      // Fan sync leader
      logic       twos;        // Temperature format select
   } fcc_cfg_t;

   typedef enum logic [1:0] {FCC_RUN, FCC_SLEEP, FCC_SPIN} fcc_sleep_t;
endpackage

// ===== logic/fcc_stretch.sv
// Smoothing interval stretch for one fan channel
`timescale 1ns/10ps
`default_nettype none
module fcc_stretch #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] base_in,
   input  wire logic         slow_x4,
   input  wire logic         extra,
   output logic [W+3:0]      stretched
);
   import fcc_pkg::*;
`include "fcc_consts.svh"
   logic [W+3:0] quad;     // Base or base times four
   logic [W+15:0] prod;    // Quad times extra factor
   assign quad = slow_x4 ? ({4'h0, base_in} << `FCC_SLOW_SHIFT) : {4'h0, base_in};
   assign prod = {12'h000, quad} * `FCC_EXTRA_NUM / `FCC_EXTRA_DEN;
   assign stretched = extra ? prod[W+3:0] : quad;
endmodule
`default_nettype wire

// ===== logic/fcc_sleep.sv
// Core-voltage-low sleep sequencer with spin-up on wake
`timescale 1ns/10ps
`default_nettype none
`include "fcc_consts.svh"
module fcc_sleep #(
   parameter int SPINUP_CYC = `FCC_SPINUP_CYC
) (
   input  wire logic CLOCK,
   input  wire logic RESET_N,
   input  wire logic enable,
   input  wire logic vlow,
   output logic      sleeping,
   output logic      spinning,
   output logic      wake_pulse
);
   import fcc_pkg::*;
   fcc_sleep_t   state_reg;   // Sequencer state
   logic [31:0]  cnt_reg;     // Spin-up counter
   wire go_sleep = enable && vlow;
   wire cnt_done = (cnt_reg == 32'(SPINUP_CYC - 1));
   // State sequencing
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg <= FCC_RUN;
         cnt_reg   <= 32'h0;
      end else begin
         unique case (state_reg)
            FCC_RUN: begin
               if (go_sleep) state_reg <= FCC_SLEEP;
            end
            FCC_SLEEP: begin
               cnt_reg <= 32'h0;
               if (!vlow) state_reg <= FCC_SPIN;
            end
            FCC_SPIN: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (go_sleep) state_reg <= FCC_SLEEP;
               else if (cnt_done) state_reg <= FCC_RUN;
            end
         endcase
      end
   end
   assign sleeping   = (state_reg == FCC_SLEEP);
   assign spinning   = (state_reg == FCC_SPIN);
   assign wake_pulse = (state_reg == FCC_SLEEP) && !vlow;
endmodule
`default_nettype wire

// ===== logic/fcc_regs.sv
// Fan controller configuration register slice
//
// Summary of operation
// - Remote one slow bit stretches fan one x4
// - Local slow bit stretches fan two x4
// - Remote two slow bit stretches fan three x4
// - Overtemperature active in manual only when enabled
// - Follower bit selects fan sync follower
// - Leader bit selects fan sync leader
// - Low core voltage sets status, alert, stops monitor
// - Recovery re-enables monitor, spins up fans
// - Extra bit stretches all intervals 39.2 percent
// - Overtemperature overrides every fan setting
// - Lock makes configuration six read-only
// - Configuration six resets to zero
// - Format bit selects twos or offset-64
// - Tach pulse setting sets pulses per measurement
`timescale 1ns/10ps
`default_nettype none
`include "fcc_consts.svh"
module fcc_regs #(
   parameter int SMOOTH_W   = 16,
   parameter int SPINUP_CYC = `FCC_SPINUP_CYC
) (
   input  wire logic                  CLOCK,
   input  wire logic                  RESET_N,
   input  wire fcc_pkg::fcc_req_t     REQ,
   output logic [7:0]                 RDATA,
   output logic                       RVALID,
   input  wire logic                  LOCK,
   input  wire logic                  MANUAL_MODE,
   input  wire logic                  OT_EVENT,
   input  wire logic                  VCORE_LOW,
   input  wire logic                  ALERT_ENABLE,
   input  wire logic [7:0]            TIMER_STATUS,
   input  wire logic [SMOOTH_W-1:0]   SMOOTH_BASE_1,
   input  wire logic [SMOOTH_W-1:0]   SMOOTH_BASE_2,
   input  wire logic [SMOOTH_W-1:0]   SMOOTH_BASE_3,
   output logic [SMOOTH_W+3:0]        SMOOTH_INT_1,
   output logic [SMOOTH_W+3:0]        SMOOTH_INT_2,
   output logic [SMOOTH_W+3:0]        SMOOTH_INT_3,
   output logic                       OT_PIN_ACTIVE,
   output logic                       FAN_FULL_OVERRIDE,
   output logic                       SYNC_FOLLOWER,
   output logic                       SYNC_LEADER,
   output logic                       VLOW_STATUS_SET,
   output logic                       SMBALERT_REQ,
   output logic                       HOT_MONITOR_EN,
   output logic                       SPINUP_REQ,
   output logic                       TEMP_TWOS,
   output logic [7:0]                 TACH_PULSES,
   output logic [7:0]                 TIMER_LIMIT
);
   import fcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] cfg6_reg;        // Smoothing, sync and sleep options
   logic [7:0] cfg3_reg;        // Configuration three
   logic [7:0] limit_reg;       // Overtemperature timer limit
   logic [7:0] tach_reg;        // Tach pulses per measurement
   logic [7:0] cfg5_reg;        // Configuration five
   logic [7:0] cfg4_reg;        // Configuration four
   logic [7:0] vcore_s1_reg;    // Core voltage low, first stage
   logic [7:0] vcore_s2_reg;    // Core voltage low, second stage
   logic       ot_s1_reg;       // Overtemperature, first stage
   logic       ot_s2_reg;       // Overtemperature, second stage
   logic       vlow_sync;       // Synchronised core voltage low

   ////////////////////////////////////////////////////////////////////////////
   // Write decode
   wire wr_cfg6  = REQ.wr_en && (REQ.addr == `FCC_ADDR_CFG6) && !LOCK;
   wire wr_cfg3  = REQ.wr_en && (REQ.addr == `FCC_ADDR_CFG3) && !LOCK;
   wire wr_limit = REQ.wr_en && (REQ.addr == `FCC_ADDR_TMR_LIMIT);
   wire wr_tach  = REQ.wr_en && (REQ.addr == `FCC_ADDR_TACH_PULSE);
   wire wr_cfg5  = REQ.wr_en && (REQ.addr == `FCC_ADDR_CFG5) && !LOCK;
   wire wr_cfg4  = REQ.wr_en && (REQ.addr == `FCC_ADDR_CFG4) && !LOCK;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register writes; test registers have no write path
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         cfg6_reg  <= `FCC_RST_CFG6;
         cfg3_reg  <= `FCC_RST_CFG3;
         limit_reg <= `FCC_RST_TMR_LIMIT;
         tach_reg  <= `FCC_RST_TACH_PULSE;
         cfg5_reg  <= `FCC_RST_CFG5;
         cfg4_reg  <= `FCC_RST_CFG4;
      end else begin
         if (wr_cfg6) cfg6_reg <= REQ.wdata;
         if (wr_cfg3) cfg3_reg <= REQ.wdata;
         if (wr_limit) limit_reg <= REQ.wdata;
         if (wr_tach) tach_reg <= REQ.wdata;
         if (wr_cfg5) cfg5_reg <= REQ.wdata;
         if (wr_cfg4) cfg4_reg <= REQ.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for the core voltage low and overtemperature levels
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         vcore_s1_reg <= 8'h00;
         vcore_s2_reg <= 8'h00;
         ot_s1_reg    <= 1'b0;
         ot_s2_reg    <= 1'b0;
      end else begin
         vcore_s1_reg <= {7'h00, VCORE_LOW};
         vcore_s2_reg <= vcore_s1_reg;
         ot_s1_reg    <= OT_EVENT;
         ot_s2_reg    <= ot_s1_reg;
      end
   end
   assign vlow_sync = vcore_s2_reg[0];

   ////////////////////////////////////////////////////////////////////////////
   // Decoded configuration
   fcc_cfg_t cfg;
   assign cfg.slow_x4   = cfg6_reg[`FCC_BIT_R2_SLOW:`FCC_BIT_R1_SLOW];
   assign cfg.extra     = cfg6_reg[`FCC_BIT_EXTRA_SLOW];
   assign cfg.ot_manual = cfg6_reg[`FCC_BIT_OT_MANUAL];
   assign cfg.follower  = cfg6_reg[`FCC_BIT_FOLLOWER];
   assign cfg.leader    = cfg6_reg[`FCC_BIT_LEADER];
   assign cfg.twos      = cfg5_reg[`FCC_BIT_TWOS];

   ////////////////////////////////////////////////////////////////////////////
   // Smoothing interval stretch per fan
   logic [SMOOTH_W+3:0] int1;   // Fan one interval
   logic [SMOOTH_W+3:0] int2;   // Fan two interval
   logic [SMOOTH_W+3:0] int3;   // Fan three interval
   fcc_stretch #(.W(SMOOTH_W)) u_st1 (
      .base_in   (SMOOTH_BASE_1),
      .slow_x4   (cfg.slow_x4[0]),
      .extra     (cfg.extra),
      .stretched (int1)
   );
   fcc_stretch #(.W(SMOOTH_W)) u_st2 (
      .base_in   (SMOOTH_BASE_2),
      .slow_x4   (cfg.slow_x4[1]),
      .extra     (cfg.extra),
      .stretched (int2)
   );
   fcc_stretch #(.W(SMOOTH_W)) u_st3 (
      .base_in   (SMOOTH_BASE_3),
      .slow_x4   (cfg.slow_x4[2]),
      .extra     (cfg.extra),
      .stretched (int3)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Core voltage low sleep sequencing
   logic sleeping;     // Hot monitor suspended
   logic spinning;     // Spin-up after wake
   logic wake_pulse;   // Core voltage back above limit
   fcc_sleep #(.SPINUP_CYC(SPINUP_CYC)) u_sleep (
      .CLOCK      (CLOCK),
      .RESET_N    (RESET_N),
      .enable     (cfg6_reg[`FCC_BIT_VLOW_SLEEP]),
      .vlow       (vlow_sync),
      .sleeping   (sleeping),
      .spinning   (spinning),
      .wake_pulse (wake_pulse)
   );
   wire vlow_hit = cfg6_reg[`FCC_BIT_VLOW_SLEEP] && vlow_sync;

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer
   logic [7:0] rd_mux;
   always_comb begin
      unique case (REQ.addr)
         `FCC_ADDR_CFG6:       rd_mux = cfg6_reg;
         `FCC_ADDR_CFG3:       rd_mux = cfg3_reg;
         `FCC_ADDR_TMR_STAT:   rd_mux = TIMER_STATUS;
         `FCC_ADDR_TMR_LIMIT:  rd_mux = limit_reg;
         `FCC_ADDR_TACH_PULSE: rd_mux = tach_reg;
         `FCC_ADDR_CFG5:       rd_mux = cfg5_reg;
         `FCC_ADDR_CFG4:       rd_mux = cfg4_reg;
         `FCC_ADDR_TEST1:      rd_mux = `FCC_RST_TEST;
         `FCC_ADDR_TEST2:      rd_mux = `FCC_RST_TEST;
         default:              rd_mux = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         RDATA             <= 8'h00;
         RVALID            <= 1'b0;
         SMOOTH_INT_1      <= '0;
         SMOOTH_INT_2      <= '0;
         SMOOTH_INT_3      <= '0;
         OT_PIN_ACTIVE     <= 1'b0;
         FAN_FULL_OVERRIDE <= 1'b0;
         SYNC_FOLLOWER     <= 1'b0;
         SYNC_LEADER       <= 1'b0;
         VLOW_STATUS_SET   <= 1'b0;
         SMBALERT_REQ      <= 1'b0;
         HOT_MONITOR_EN    <= 1'b1;
         SPINUP_REQ        <= 1'b0;
         TEMP_TWOS         <= 1'b1;
         TACH_PULSES       <= `FCC_RST_TACH_PULSE;
         TIMER_LIMIT       <= `FCC_RST_TMR_LIMIT;
      end else begin
         RDATA             <= REQ.rd_en ? rd_mux : RDATA;
         RVALID            <= REQ.rd_en;
         SMOOTH_INT_1      <= int1;
         SMOOTH_INT_2      <= int2;
         SMOOTH_INT_3      <= int3;
         OT_PIN_ACTIVE     <= !MANUAL_MODE || cfg.ot_manual;
         FAN_FULL_OVERRIDE <= ot_s2_reg;
         SYNC_FOLLOWER     <= cfg.follower;
         SYNC_LEADER       <= cfg.leader;
         VLOW_STATUS_SET   <= vlow_hit;
         SMBALERT_REQ      <= vlow_hit && ALERT_ENABLE;
         HOT_MONITOR_EN    <= !(sleeping && !wake_pulse) && !vlow_hit;
         SPINUP_REQ        <= spinning || wake_pulse;
         TEMP_TWOS         <= cfg.twos;
         TACH_PULSES       <= tach_reg;
         TIMER_LIMIT       <= limit_reg;
      end
   end
endmodule
`default_nettype wire

// ===== sim/fcc_regs_monitor.sv
// Assertion checker for the fan configuration register slice
`timescale 1ns/10ps
`default_nettype none
module fcc_regs_chk (
   input wire logic              CLOCK,
   input wire logic              RESET_N,
   input wire fcc_pkg::fcc_req_t REQ,
   input wire logic [7:0]        RDATA,
   input wire logic              RVALID,
   input wire logic              MANUAL_MODE,
   input wire logic              OT_EVENT,
   input wire logic              ALERT_ENABLE,
   input wire logic              OT_PIN_ACTIVE,
   input wire logic              FAN_FULL_OVERRIDE,
   input wire logic              VLOW_STATUS_SET,
   input wire logic              SMBALERT_REQ,
   input wire logic              HOT_MONITOR_EN,
   input wire logic              SPINUP_REQ,
   input wire logic              TEMP_TWOS,
   input wire logic [7:0]        TACH_PULSES
);
   import fcc_pkg::*;
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////////////
   // Event held or gone long enough to cross the two-stage synchroniser
   sequence s_ot_held;
      OT_EVENT [*3];
   endsequence
   sequence s_ot_gone;
      !OT_EVENT [*3];
   endsequence
   a_ot_override_set: assert property (s_ot_held |=> FAN_FULL_OVERRIDE)
      else $error("override missing after event");
   a_ot_override_clr: assert property (s_ot_gone |=> !FAN_FULL_OVERRIDE)
      else $error("override stuck after event");
   a_auto_pin_on: assert property (!MANUAL_MODE |=> OT_PIN_ACTIVE)
      else $error("overtemperature pin off in automatic mode");
   a_alert_from_status: assert property (SMBALERT_REQ |-> VLOW_STATUS_SET && $past(ALERT_ENABLE))
      else $error("alert without enabled status");
   a_monitor_off_vlow: assert property (VLOW_STATUS_SET |-> !HOT_MONITOR_EN)
      else $error("monitor left on at low core voltage");
   a_spinup_on_wake: assert property ($fell(VLOW_STATUS_SET) |-> ##[0:4] SPINUP_REQ)
      else $error("no spin-up after wake");
   a_spinup_ends: assert property ($rose(SPINUP_REQ) |-> HOT_MONITOR_EN ##[1:10] !SPINUP_REQ)
      else $error("spin-up too long or monitor off");
   a_test_reads_zero: assert property (REQ.rd_en && REQ.addr >= 8'h7e |=> RVALID && RDATA == 8'h00)
      else $error("test register read not zero");
   a_pulses_written: assert property (REQ.wr_en && REQ.addr == 8'h7b |=> ##1 TACH_PULSES == $past(REQ.wdata, 2))
      else $error("pulse setting not applied");
   a_reset_defaults: assert property ($rose(RESET_N) |-> TEMP_TWOS && TACH_PULSES == 8'h55)
      else $error("format or pulse default wrong");
endmodule
bind fcc_regs fcc_regs_chk i_fcc_regs_chk (.CLOCK(CLOCK), .RESET_N(RESET_N), .REQ(REQ), .RDATA(RDATA),
   .RVALID(RVALID), .MANUAL_MODE(MANUAL_MODE), .OT_EVENT(OT_EVENT), .ALERT_ENABLE(ALERT_ENABLE),
   .OT_PIN_ACTIVE(OT_PIN_ACTIVE), .FAN_FULL_OVERRIDE(FAN_FULL_OVERRIDE), .VLOW_STATUS_SET(VLOW_STATUS_SET),
   .SMBALERT_REQ(SMBALERT_REQ), .HOT_MONITOR_EN(HOT_MONITOR_EN), .SPINUP_REQ(SPINUP_REQ),
   .TEMP_TWOS(TEMP_TWOS), .TACH_PULSES(TACH_PULSES));
`default_nettype wire

// ===== sim/fcc_host.sv
// Register host model issuing single-byte requests
`timescale 1ns/10ps
`default_nettype none
module fcc_host (
   input  wire logic            CLOCK,
   output var fcc_pkg::fcc_req_t REQ
);
   import fcc_pkg::*;
   initial REQ = '0;
   // Request held over one rising edge, then dropped with strobes cleared and inverted address and data
   task automatic issue(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge CLOCK);
      REQ <= '{wr_en: w, rd_en: !w, addr: a, wdata: d};
      @(negedge CLOCK);
      REQ <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // Writes skip the factory test pair
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a[7:1] != 7'h3f) issue(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      issue(1'b0, a, 8'h00);
   endtask
endmodule
`default_nettype wire

// ===== sim/fcc_regs_test.sv
// Self-checking bench for the fan configuration register slice
`timescale 1ns/10ps
`default_nettype none
module fcc_regs_test;
   import fcc_pkg::*;
   localparam int SPIN = 8;                       // Shortened spin-up
   logic              clock, reset_n, lock, manual, ot, vlow, alert;
   logic [7:0]        tstat, rdata, pulses, tlim, d;
   logic [15:0]       b1, b2, b3;
   logic [19:0]       s1, s2, s3;
   logic              rvalid, ot_pin, ovr, fol, lead, vst, alrt, hmon, spin, twos;
   fcc_req_t          req;
   logic [7:0]        sh [256];                  // Expected register contents
   logic [7:0]        exp_q [$];                 // Expected read data
   logic [7:0]        regs [10] = '{8'h10, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'h20};
   int                n_fail, checked, n;
   fcc_host i_fcc_host (.CLOCK(clock), .REQ(req));
   fcc_regs #(.SPINUP_CYC(SPIN)) i_fcc_regs (.CLOCK(clock), .RESET_N(reset_n), .REQ(req), .RDATA(rdata),
      .RVALID(rvalid), .LOCK(lock), .MANUAL_MODE(manual), .OT_EVENT(ot), .VCORE_LOW(vlow),
      .ALERT_ENABLE(alert), .TIMER_STATUS(tstat), .SMOOTH_BASE_1(b1), .SMOOTH_BASE_2(b2), .SMOOTH_BASE_3(b3),
      .SMOOTH_INT_1(s1), .SMOOTH_INT_2(s2), .SMOOTH_INT_3(s3), .OT_PIN_ACTIVE(ot_pin),
      .FAN_FULL_OVERRIDE(ovr), .SYNC_FOLLOWER(fol), .SYNC_LEADER(lead), .VLOW_STATUS_SET(vst),
      .SMBALERT_REQ(alrt), .HOT_MONITOR_EN(hmon), .SPINUP_REQ(spin), .TEMP_TWOS(twos),
      .TACH_PULSES(pulses), .TIMER_LIMIT(tlim));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string nm, input logic [19:0] e, input logic [19:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic conclude;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Shadow update only for writable places not blocked by the lock
   task automatic w(input logic [7:0] a, input logic [7:0] v);
      i_fcc_host.wr(a, v);
      if (a inside {8'h7a, 8'h7b} || (a inside {8'h10, 8'h78, 8'h7c, 8'h7d} && !lock)) sh[a] = v;
   endtask
   task automatic r(input logic [7:0] a);
      exp_q.push_back(a == 8'h79 ? tstat : sh[a]);
      i_fcc_host.rd(a);
   endtask
   function automatic logic [19:0] stretch(input logic [15:0] b, input logic s, input logic e);
      logic [31:0] v;
      v = s ? 32'(b) << 2 : 32'(b);
      if (e) v = v * 1392 / 1000;
      return v[19:0];
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and read-data watcher
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      #(25 * 5000);
      n_fail++;
      conclude();
   end
   always @(negedge clock) if (rvalid === 1'b1) cmp("rdata", exp_q.pop_front(), rdata);
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hc12fe452));
      {reset_n, lock, manual, ot, vlow, alert} = '0;
      tstat = 8'($urandom);
      {b1, b2, b3} = 48'($urandom);
      foreach (sh[i]) sh[i] = 8'h00;
      sh[8'h7b] = 8'h55;
      sh[8'h7c] = 8'h01;
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      cmp("twos", 1, twos);
      foreach (regs[i]) r(regs[i]);
      // Random configuration six values drive stretch, sync and pin outputs
      repeat (8) begin
         d = $urandom & 8'hbf;
         {b1, b2, b3} = 48'({$urandom, $urandom});
         manual = 1'($urandom);
         w(8'h10, d);
         d = sh[8'h10];                           // Lock may have kept the old value
         repeat (3) @(negedge clock);
         cmp("int1", stretch(b1, d[0], d[7]), s1);
         cmp("int2", stretch(b2, d[1], d[7]), s2);
         cmp("int3", stretch(b3, d[2], d[7]), s3);
         cmp("pin", !manual | d[3], ot_pin);
         cmp("sync", d[5:4], {lead, fol});
         foreach (regs[i]) w(regs[i], $urandom);
         repeat (2) @(negedge clock);
         cmp("twos", sh[8'h7c][0], twos);
         cmp("pulses", sh[8'h7b], pulses);
         cmp("limit", sh[8'h7a], tlim);
         lock = $urandom;
         foreach (regs[i]) r(regs[i]);
      end
      lock = 1'b0;
      // Low core voltage sleep, alert, then wake with spin-up
      w(8'h10, 8'h40);
      alert = 1'b1;
      vlow = 1'b1;
      for (n = 0; n < 10 && vst !== 1'b1; n++) @(negedge clock);
      cmp("vlow", 3'b110, {vst, alrt, hmon});
      alert = 1'b0;
      @(negedge clock);
      cmp("alert", 0, alrt);
      vlow = 1'b0;
      for (n = 0; n < 10 && spin !== 1'b1; n++) @(negedge clock);
      cmp("wake", 2'b11, {spin, hmon});
      for (n = 0; n < SPIN + 4 && spin !== 1'b0; n++) @(negedge clock);
      cmp("spin", 0, spin);
      // Manual mode pin enable and event override
      manual = 1'b1;
      w(8'h10, 8'h00);
      repeat (3) @(negedge clock);
      cmp("pin", 0, ot_pin);
      ot = 1'b1;
      repeat (4) @(negedge clock);
      cmp("ovr", 1, ovr);
      ot = 1'b0;
      w(8'h10, 8'h08);
      repeat (3) @(negedge clock);
      cmp("pin", 1, ot_pin);
      cmp("ovr", 0, ovr);
      conclude();
   end
endmodule
`default_nettype wire
